/* File: inc/ifl_pkg.sv */
// package of register map, field positions and reset values
package ifl_pkg;
  localparam logic [7:0] ADDR_INTCTL = 8'h0b;
  localparam logic [7:0] ADDR_PFLAGS = 8'h0c;
  localparam logic [7:0] ADDR_PENABLES = 8'h8c;
  localparam logic [7:0] ADDR_OPTION = 8'h81;
  localparam logic [7:0] ADDR_MASK = 8'h90;
  localparam int BIT_PCF = 0;
  localparam int BIT_PIF = 1;
  localparam int BIT_TOF = 2;
  localparam int BIT_PCE = 3;
  localparam int BIT_PIE = 4;
  localparam int BIT_TOE = 5;
  localparam int BIT_PGE = 6;
  localparam int BIT_GIE = 7;
  localparam int BIT_CMP = 6;
  localparam int BIT_PSP = 7;
  localparam int BIT_EDGE = 6;
  localparam logic [7:0] RST_INTCTL = 8'h00;
  localparam logic [7:0] RST_PERIPH = 8'h00;
  localparam logic [7:0] RST_OPTION = 8'hff;
  localparam logic [7:0] PERIPH_MASK = 8'hc0;
  localparam logic [7:0] RETURN_OPCODE = 8'h09;
  localparam int RETURN_CYCLES = 2;
endpackage

/* File: inc/ifl_evt_if.sv */
// interface carrying detected events from detector to top
`timescale 1ns/1ns
interface ifl_evt_if;
  logic pinEdge;
  logic portChange;
  logic timerWrap;
  modport src (output pinEdge, output portChange, output timerWrap);
  modport dst (input pinEdge, input portChange, input timerWrap);
endinterface

/* File: hw/ifl_event_detect.sv */
// edge, change and overflow detectors for interrupt sources
`timescale 1ns/1ns
module ifl_event_detect (
  input wire logic coreClk,
  input wire logic rstN,
  input wire logic edgeSelect,
  input wire logic pinLevel,
  input wire logic [3:0] portHigh,
  input wire logic timerTick,
  input wire logic [7:0] timerValue,
  ifl_evt_if.src evt
);
  logic pinLast_reg;
  logic [3:0] portLast_reg;
  logic primed_reg;
  always_ff @(posedge coreClk or negedge rstN) begin
    if (!rstN) begin
      pinLast_reg <= 1'b0;
      portLast_reg <= 4'h0;
      primed_reg <= 1'b0;
    end else begin
      pinLast_reg <= pinLevel;
      portLast_reg <= portHigh;
      primed_reg <= 1'b1;
    end
  end
  assign evt.pinEdge = primed_reg & (edgeSelect ? (pinLevel & ~pinLast_reg)
    : (~pinLevel & pinLast_reg)); // R01
  assign evt.portChange = primed_reg & (portHigh != portLast_reg); // R09
  assign evt.timerWrap = timerTick & (timerValue == 8'hff); // R07
endmodule

/* File: hw/ifl_return_from_interrupt_seq.sv */
// two-cycle return-from-interrupt sequencer
`timescale 1ns/1ns
module ifl_return_from_interrupt_seq (
  input wire logic coreClk,
  input wire logic rstN,
  input wire logic start,
  output logic setGlobal,
  output logic busy
);
  typedef enum logic [1:0] {
    IDLE = 2'b01,
    POP = 2'b10
  } ifl_ret_type;
  ifl_ret_type state_reg;
  always_ff @(posedge coreClk or negedge rstN) begin
    if (!rstN) begin
      state_reg <= IDLE;
    end else begin
      unique case (state_reg)
        IDLE: begin
          if (start) begin
            state_reg <= POP;
          end
        end
        POP: begin
          state_reg <= IDLE;
        end
        default: begin
          state_reg <= IDLE;
        end
      endcase
    end
  end
  assign busy = (state_reg == POP) | start;
  assign setGlobal = (state_reg == POP); // R15
endmodule

/* File: hw/ifl_interrupt_logic.sv */
// interrupt flag and enable logic with register port
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
// Functional notes
// R01 - pin interrupt on selected rising/falling edge
// R02 - valid edge sets pin flag bit 1
// R03 - bit 4 enables pin interrupt
// R04 - pin flag stays set until software clears
// R05 - pin edge wakes sleep if enabled before
// R06 - vector after wake only with global enable
// R07 - timer wrap sets timer flag bit 2
// R08 - bit 5 enables timer interrupt
// R09 - port high-nibble change sets flag bit 0
// R10 - port change has separate enable bit
// R11 - software masks comparator during mode change
// R12 - control bit order; reset clears all
// R13 - software keeps parallel bits zero if absent
// R14 - flags set regardless of enables
// R15 - return sets global enable over two cycles
// R16 - request from gated core or peripheral flags
module ifl_interrupt_logic (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic externalInterruptPin,
  input wire logic [3:0] portBHigh,
  input wire logic timerTick,
  input wire logic [7:0] timerZeroCounter,
  input wire logic comparatorEvent,
  input wire logic parallelPortEvent,
  input wire logic sleepEnter,
  input wire logic returnFromInterrupt,
  input wire logic vectorTaken,
  output logic interruptRequest,
  output logic wakeUp,
  output logic branchToVector,
  output logic returnBusy,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] intCtl_reg;
  logic [7:0] pFlags_reg;
  logic [7:0] pEnables_reg;
  logic [7:0] option_reg;
  logic [7:0] mask_reg;
  logic [7:0] rdata_reg;
  logic sleeping_reg;
  logic pinEnableAtSleep_reg;
  logic wake_reg;
  logic branch_reg;
  logic setGlobal;
  logic wrCtl;
  logic wrPfl;
  ifl_evt_if evt ();

  function automatic logic [7:0] w1cSet(input logic [7:0] cur,
    input logic [7:0] set, input logic [7:0] wr, input logic en);
    w1cSet = set | (cur & ~(en ? wr : 8'h00));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  ifl_event_detect u_detect (
    .coreClk(core_clk),
    .rstN(rst_n),
    .edgeSelect(option_reg[ifl_pkg::BIT_EDGE]),
    .pinLevel(externalInterruptPin),
    .portHigh(portBHigh),
    .timerTick(timerTick),
    .timerValue(timerZeroCounter),
    .evt(evt)
  );

  ifl_return_from_interrupt_seq u_ret (
    .coreClk(core_clk),
    .rstN(rst_n),
    .start(returnFromInterrupt),
    .setGlobal(setGlobal),
    .busy(returnBusy)
  );

  ////////////////////////////////////////////////////////////////////////
  assign wrCtl = regWrite & (regAddr == ifl_pkg::ADDR_INTCTL);
  assign wrPfl = regWrite & (regAddr == ifl_pkg::ADDR_PFLAGS);

  // control register: flags set on event, cleared by writing zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      intCtl_reg <= ifl_pkg::RST_INTCTL; // R12
    end else begin
      if (wrCtl) begin
        intCtl_reg <= regWdata;
      end
      if (vectorTaken) begin
        intCtl_reg[ifl_pkg::BIT_GIE] <= 1'b0;
      end
      if (setGlobal) begin
        intCtl_reg[ifl_pkg::BIT_GIE] <= 1'b1; // R15
      end
      if (evt.pinEdge) begin
        intCtl_reg[ifl_pkg::BIT_PIF] <= 1'b1; // R02 R04 R14
      end
      if (evt.timerWrap) begin
        intCtl_reg[ifl_pkg::BIT_TOF] <= 1'b1; // R07 R14
      end
      if (evt.portChange) begin
        intCtl_reg[ifl_pkg::BIT_PCF] <= 1'b1; // R09 R14
      end
    end
  end

  // peripheral flags: set wins over software write of zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pFlags_reg <= ifl_pkg::RST_PERIPH;
    end else begin
      pFlags_reg <= ((wrPfl ? regWdata : pFlags_reg)
        | {parallelPortEvent, comparatorEvent, 6'h00})
        & ifl_pkg::PERIPH_MASK; // R14
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pEnables_reg <= ifl_pkg::RST_PERIPH;
      option_reg <= ifl_pkg::RST_OPTION;
      mask_reg <= 8'h00;
    end else if (regWrite) begin
      if (regAddr == ifl_pkg::ADDR_PENABLES) begin
        pEnables_reg <= regWdata & ifl_pkg::PERIPH_MASK;
      end
      if (regAddr == ifl_pkg::ADDR_OPTION) begin
        option_reg <= regWdata;
      end
      if (regAddr == ifl_pkg::ADDR_MASK) begin
        mask_reg <= regWdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic pinHit;
  logic otherHit;
  logic periphHit;
  logic anyPending;
  assign pinHit = intCtl_reg[ifl_pkg::BIT_PIE] // R03
    & intCtl_reg[ifl_pkg::BIT_PIF];
  // every enabled source except the pin, also used for wake
  assign otherHit = periphHit
    | (intCtl_reg[ifl_pkg::BIT_TOE] & intCtl_reg[ifl_pkg::BIT_TOF]) // R08
    | (intCtl_reg[ifl_pkg::BIT_PCE] & intCtl_reg[ifl_pkg::BIT_PCF]); // R10
  assign periphHit = intCtl_reg[ifl_pkg::BIT_PGE]
    & (|(pFlags_reg & pEnables_reg));
  assign anyPending = pinHit | otherHit;
  assign interruptRequest = intCtl_reg[ifl_pkg::BIT_GIE] & anyPending; // R16

  // sleep tracking and wake
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleeping_reg <= 1'b0;
      pinEnableAtSleep_reg <= 1'b0;
      wake_reg <= 1'b0;
      branch_reg <= 1'b0;
    end else begin
      wake_reg <= 1'b0;
      branch_reg <= 1'b0;
      if (sleepEnter & ~sleeping_reg) begin
        sleeping_reg <= 1'b1;
        pinEnableAtSleep_reg <= intCtl_reg[ifl_pkg::BIT_PIE];
      end else if (sleeping_reg & ((evt.pinEdge & pinEnableAtSleep_reg)
        | otherHit)) begin
        sleeping_reg <= 1'b0; // R05
        wake_reg <= 1'b1;
        branch_reg <= intCtl_reg[ifl_pkg::BIT_GIE]; // R06
      end
    end
  end
  assign wakeUp = wake_reg;
  assign branchToVector = branch_reg;
  assign irq = |(intCtl_reg[2:0] & mask_reg[2:0])
    | |(pFlags_reg & mask_reg & ifl_pkg::PERIPH_MASK);

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        ifl_pkg::ADDR_INTCTL: rdata_reg <= intCtl_reg;
        ifl_pkg::ADDR_PFLAGS: rdata_reg <= pFlags_reg;
        ifl_pkg::ADDR_PENABLES: rdata_reg <= pEnables_reg;
        ifl_pkg::ADDR_OPTION: rdata_reg <= option_reg;
        ifl_pkg::ADDR_MASK: rdata_reg <= mask_reg;
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end
  assign regRdata = rdata_reg;
endmodule

/* File: sim/ifl_core_model.sv */
// core model that takes the vector on a request while ackEnable is high
`timescale 1ns/1ns
module ifl_core_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic interruptRequest,
  input wire logic ackEnable,
  output logic vectorTaken
);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vectorTaken <= 1'b0;
    end else begin
      vectorTaken <= ackEnable && interruptRequest && !vectorTaken;
    end
  end
endmodule

/* File: sim/ifl_chk_asserts.sv */
// port timing checker for interrupt flag logic
`timescale 1ns/1ns
module ifl_chk_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic returnFromInterrupt,
  input wire logic interruptRequest,
  input wire logic wakeUp,
  input wire logic branchToVector,
  input wire logic returnBusy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (
    !regRead |=> regRdata == 8'h00)
    else $error("read data not zero without read");
  a_busy_two: assert property (
    returnFromInterrupt |-> returnBusy ##1 returnBusy)
    else $error("return busy not two cycles");
  a_busy_end: assert property (
    returnBusy |-> returnFromInterrupt || $past(returnFromInterrupt))
    else $error("return busy too long");
  a_ret_global: assert property (
    returnFromInterrupt ##1 !regWrite
    ##1 (regRead && regAddr == ifl_pkg::ADDR_INTCTL) |=> regRdata[7])
    else $error("global enable not set by return");
  a_branch_wake: assert property (
    branchToVector |-> wakeUp)
    else $error("branch without wake");
  a_req_off: assert property (
    regWrite && regAddr == ifl_pkg::ADDR_INTCTL && !regWdata[7]
    && !returnBusy |=> !interruptRequest)
    else $error("request with global enable off");
  a_periph_low: assert property (
    regRead && regAddr == ifl_pkg::ADDR_PFLAGS
    |=> regRdata[5:0] == 6'h00)
    else $error("peripheral low bits not zero");
  a_wake_pulse: assert property (
    wakeUp |=> !wakeUp)
    else $error("wake not a pulse");
endmodule
////////////////////////////////////////////////////////////////////////////
bind ifl_interrupt_logic ifl_chk_asserts chk (.*);

/* File: sim/ifl_interrupt_logic_tb.sv */
// testbench of interrupt flag and enable logic
`timescale 1ns/1ns
module ifl_interrupt_logic_tb;
  logic core_clk = 0, rst_n = 0, regWrite = 0, regRead = 0, pin = 0;
  logic tick = 0, cmpEv = 0, parEv = 0, slp = 0, rfi = 0, ackEn = 0;
  logic [7:0] addr = 0, wdata = 0, cnt = 0, rdata;
  logic [3:0] portHi = 0;
  logic vec, req, wake, branch, busy, irq;
  int miscompares = 0, num_checks = 0;
  localparam logic [7:0] CTL = ifl_pkg::ADDR_INTCTL;
  localparam logic [7:0] PF = ifl_pkg::ADDR_PFLAGS;
  localparam logic [7:0] PE = ifl_pkg::ADDR_PENABLES;
  ifl_interrupt_logic uut (.core_clk(core_clk), .rst_n(rst_n),
    .regAddr(addr), .regWdata(wdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(rdata), .externalInterruptPin(pin),
    .portBHigh(portHi), .timerTick(tick), .timerZeroCounter(cnt),
    .comparatorEvent(cmpEv), .parallelPortEvent(parEv), .sleepEnter(slp),
    .returnFromInterrupt(rfi), .vectorTaken(vec), .interruptRequest(req),
    .wakeUp(wake), .branchToVector(branch), .returnBusy(busy), .irq(irq));
  ifl_core_model core (.core_clk(core_clk), .rst_n(rst_n),
    .interruptRequest(req), .ackEnable(ackEn), .vectorTaken(vec));
  initial forever #2 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    #1;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    addr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic ev(input int k);
    @(posedge core_clk);
    case (k)
      0: pin <= ~pin;
      1: tick <= 1'b1;
      2: cmpEv <= 1'b1;
      3: parEv <= 1'b1;
      4: slp <= 1'b1;
      default: rfi <= 1'b1;
    endcase
    @(posedge core_clk);
    {tick, cmpEv, parEv, slp, rfi} <= 5'h00;
    #1;
  endtask
  task automatic rise();
    if (pin) ev(0);
    ev(0);
  endtask
  task automatic wk(input logic [7:0] e);
    logic [7:0] got;
    got = 8'h00;
    repeat (6) begin
      #1;
      if (wake === 1'b1) got = {6'h00, wake, branch};
      @(posedge core_clk);
    end
    chk(got, e);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rc(CTL, 8'h00);
    rc(PF, 8'h00);
    rc(PE, 8'h00);
    rc(ifl_pkg::ADDR_OPTION, 8'hff);
  endtask
  task automatic t_pin();
    rise();
    rc(CTL, 8'h02);
    wr(CTL, 8'h00);
    rc(CTL, 8'h00);
    wr(ifl_pkg::ADDR_OPTION, 8'hbf);
    ev(0);
    rc(CTL, 8'h02);
    wr(CTL, 8'h00);
    ev(0);
    rc(CTL, 8'h00);
    wr(ifl_pkg::ADDR_OPTION, 8'hff);
  endtask
  task automatic t_timer_port();
    @(posedge core_clk);
    cnt <= 8'hfe;
    ev(1);
    rc(CTL, 8'h00);
    @(posedge core_clk);
    cnt <= 8'hff;
    ev(1);
    rc(CTL, 8'h04);
    wr(CTL, 8'h00);
    @(posedge core_clk);
    portHi <= 4'h8;
    rc(CTL, 8'h01);
    wr(CTL, 8'h00);
  endtask
  task automatic t_req();
    wr(CTL, 8'h10);
    rise();
    chk(req, 8'h00);
    wr(CTL, 8'h92);
    chk(req, 8'h01);
    wr(CTL, 8'h82);
    chk(req, 8'h00);
    wr(CTL, 8'ha0);
    ev(1);
    chk(req, 8'h01);
    wr(CTL, 8'h8c);
    chk(req, 8'h00);
    @(posedge core_clk);
    portHi <= 4'h0;
    rc(CTL, 8'h8d);
    chk(req, 8'h01);
    wr(CTL, 8'h85);
    chk(req, 8'h00);
  endtask
  task automatic t_vector();
    @(posedge core_clk);
    ackEn <= 1'b1;
    wr(CTL, 8'h89);
    repeat (3) @(posedge core_clk);
    ackEn <= 1'b0;
    rc(CTL, 8'h09);
    ev(5);
    #1;
    chk(busy, 8'h01);
    rc(CTL, 8'h89);
    wr(CTL, 8'h00);
  endtask
  task automatic t_periph();
    ev(2);
    rc(PF, 8'h40);
    ev(3);
    rc(PF, 8'hc0);
    wr(PE, 8'hc0);
    rc(PE, 8'hc0);
    wr(CTL, 8'hc0);
    chk(req, 8'h01);
    wr(CTL, 8'h80);
    chk(req, 8'h00);
    wr(ifl_pkg::ADDR_MASK, 8'h40);
    chk(irq, 8'h01);
    wr(PF, 8'h80);
    chk(irq, 8'h00);
    rc(8'h55, 8'h00);
    wr(PF, 8'h00);
    wr(PE, 8'h00);
  endtask
  task automatic t_sleep();
    wr(CTL, 8'h00);
    ev(4);
    rise();
    wk(8'h00);
    wr(CTL, 8'h20);
    ev(1);
    wk(8'h02);
    wr(CTL, 8'h10);
    ev(4);
    rise();
    wk(8'h02);
    wr(CTL, 8'h90);
    ev(4);
    rise();
    wk(8'h03);
    wr(CTL, 8'h00);
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_reset();
    t_pin();
    t_timer_port();
    t_req();
    t_vector();
    t_periph();
    t_sleep();
    report_and_stop();
  end
  initial begin
    #40000;
    miscompares++;
    report_and_stop();
  end
endmodule
